// file: rtl/ccr_clk_ctrl.sv
// Serial control registers and output gating of the clock generator
`timescale 1ns/1ps
// How it works
// - Bus gate byte: one runs, resets all ones
// - Bit 6 bus clock 0, bits 0-4 clocks 1-5
// - Memory byte bit 6 picks shared pin rate
// - Memory byte bit 5 gates fixed high-rate output
// - Memory byte bit 4 gates shared-rate output
// - Bits 2..0 gate memory clock groups
// - Spread byte top nibble returns latched straps
// - Spread bit 1 selects modulation depth
// - Spread bit 0 enables modulation, resets zero
// - Reference byte bits 1,0 gate reference outputs
// - Byte six is a fixed read-only code
// - Answer our address, ack, read from zero
module ccr_clk_ctrl (
	// Clock, reset and freeze
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	// Serial slave pins (open drain data)
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// Frequency strap pins
	input  wire logic [3:0]  freq_strap_n,
	// Ungated clock sources
	input  wire logic        bus_clock_src,
	input  wire logic        mem_clock_src,
	input  wire logic        low_rate_src,
	input  wire logic        high_rate_src,
	input  wire logic [1:0]  reference_src,
	// Gated clock outputs
	output logic [5:0]       bus_clock_out,
	output logic [11:0]      memory_clock_out,
	output logic             shared_rate_clock_out,
	output logic             fixed_high_rate_clock_out,
	output logic [1:0]       reference_out,
	// Spread spectrum control
	output logic             spread_enable,
	output logic             spread_depth_half
);

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	ccr_pkg::ccr_pins_t pins;
	ccr_pkg::ccr_pins_t s1_ff;
	ccr_pkg::ccr_pins_t s2_ff;
	logic               scl_q_ff;
	logic               sda_q_ff;

	assign pins = '{scl: scl_in, sda: sda_in, strap_n: freq_strap_n, bus_src: bus_clock_src,
		mem_src: mem_clock_src, r24_src: low_rate_src, r48_src: high_rate_src, ref_src: reference_src};

	// Sources are sampled on mclk, so they must run well below half its rate
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s1_ff    <= '0;
			s2_ff    <= '0;
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end else if (ce) begin
			s1_ff    <= pins;
			s2_ff    <= s1_ff;
			scl_q_ff <= s2_ff.scl;
			sda_q_ff <= s2_ff.sda;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	// Bus events compare the second stage with the registered stage after it
	assign scl_rise  = s2_ff.scl & ~scl_q_ff;
	assign scl_fall  = ~s2_ff.scl & scl_q_ff;
	assign bus_start = s2_ff.scl & scl_q_ff & sda_q_ff & ~s2_ff.sda;
	assign bus_stop  = s2_ff.scl & scl_q_ff & ~sda_q_ff & s2_ff.sda;

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	ccr_pkg::ccr_state_t st_ff, nxt_st;
	logic [2:0] cnt_ff, nxt_cnt;
	logic [7:0] shift_ff, nxt_shift;
	logic       got_ff, nxt_got;
	logic       rw_ff, nxt_rw;
	logic [1:0] hdr_ff, nxt_hdr;
	logic [2:0] idx_ff, nxt_idx;
	logic       oe_ff, nxt_oe;
	logic [7:0] bus_ff, nxt_bus;
	logic [7:0] mem_ff, nxt_mem;
	logic [1:0] spr_ff, nxt_spr;
	logic [1:0] ref_ff, nxt_ref;
	logic       sel_ff, nxt_sel;
	logic [3:0] strap_ff, nxt_strap;
	logic [1:0] wait_ff, nxt_wait;
	logic       sdone_ff, nxt_sdone;
	logic [7:0] rx_byte;
	logic       wr_en;

	// Read-back image of one byte of the sequence
	function automatic logic [7:0] rd_byte(input logic [2:0] idx, input logic [7:0] bus,
		input logic [7:0] mem, input logic [1:0] spr, input logic [1:0] rf, input logic [3:0] strap);
		logic [7:0] val;
		val = ccr_pkg::BYTE_ZERO;
		unique case (idx)
			ccr_pkg::IDX_BUS: val = bus;
			ccr_pkg::IDX_MEM: val = mem;
			ccr_pkg::IDX_SPR: val = {strap, ccr_pkg::RSV_ZERO2, spr};
			ccr_pkg::IDX_REF: val = {ccr_pkg::RSV_ZERO6, rf};
			ccr_pkg::IDX_ID:  val = ccr_pkg::CHIP_ID;
			default:          val = ccr_pkg::BYTE_ZERO;
		endcase
		return val;
	endfunction : rd_byte

	assign rx_byte = {shift_ff[6:0], s2_ff.sda};
	assign wr_en   = ce && st_ff == ccr_pkg::ST_WRITE && scl_rise && cnt_ff == ccr_pkg::BIT_LAST
		&& hdr_ff == ccr_pkg::HDR_BYTES;

	// Slave sequencer, register writes, strap capture and rate select
	always_comb begin
		nxt_st = st_ff;  nxt_cnt = cnt_ff;  nxt_shift = shift_ff;  nxt_got = got_ff;
		nxt_rw = rw_ff;  nxt_hdr = hdr_ff;  nxt_idx = idx_ff;  nxt_oe = oe_ff;
		nxt_bus = bus_ff;  nxt_mem = mem_ff;  nxt_spr = spr_ff;  nxt_ref = ref_ff;
		nxt_sel = sel_ff;  nxt_strap = strap_ff;  nxt_wait = wait_ff;  nxt_sdone = sdone_ff;
		if (ce) begin
			// Straps are caught once, after reset and the synchroniser settle
			if (!sdone_ff) begin
				nxt_wait = wait_ff + 2'h1;
				if (wait_ff == ccr_pkg::STRAP_WAIT) begin
					nxt_strap = s2_ff.strap_n;
					nxt_sdone = 1'b1;
				end
			end
			// Rate select moves only with both sources low to avoid a runt
			if (!s2_ff.r24_src && !s2_ff.r48_src) begin
				nxt_sel = mem_ff[ccr_pkg::MEM_SEL];
			end
			if (bus_start) begin
				nxt_st = ccr_pkg::ST_ADDR;  nxt_cnt = 3'h0;  nxt_got = 1'b0;
				nxt_hdr = 2'h0;  nxt_idx = ccr_pkg::IDX_FIRST;  nxt_oe = 1'b0;
			end else if (bus_stop) begin
				nxt_st = ccr_pkg::ST_IDLE;  nxt_oe = 1'b0;
			end else begin
				unique case (st_ff)
					ccr_pkg::ST_IDLE: nxt_oe = 1'b0;
					ccr_pkg::ST_ADDR: begin
						if (scl_rise) begin
							nxt_shift = rx_byte;
							nxt_cnt = cnt_ff + 3'h1;
							if (cnt_ff == ccr_pkg::BIT_LAST) begin
								if (rx_byte[7:1] == ccr_pkg::SLAVE_ADDR) begin
									nxt_got = 1'b1;
									nxt_rw = rx_byte[0];
								end else begin
									nxt_st = ccr_pkg::ST_IDLE;
								end
							end
						end else if (scl_fall && got_ff) begin
							nxt_oe = 1'b1;  nxt_got = 1'b0;  nxt_st = ccr_pkg::ST_ACK;
						end
					end
					ccr_pkg::ST_ACK: begin
						if (scl_fall) begin
							nxt_cnt = 3'h0;
							if (rw_ff) begin
								nxt_shift = rd_byte(idx_ff, bus_ff, mem_ff, spr_ff, ref_ff, strap_ff);
								nxt_oe = ~nxt_shift[7];
								nxt_st = ccr_pkg::ST_READ;
							end else begin
								nxt_oe = 1'b0;
								nxt_st = ccr_pkg::ST_WRITE;
							end
						end
					end
					ccr_pkg::ST_WRITE: begin
						if (scl_rise) begin
							nxt_shift = rx_byte;
							nxt_cnt = cnt_ff + 3'h1;
							if (cnt_ff == ccr_pkg::BIT_LAST) begin
								nxt_got = 1'b1;
								if (hdr_ff != ccr_pkg::HDR_BYTES) begin
									nxt_hdr = hdr_ff + 2'h1;
								end else begin
									if (idx_ff != ccr_pkg::IDX_MAX) nxt_idx = idx_ff + 3'h1;
									unique case (idx_ff)
										ccr_pkg::IDX_BUS: nxt_bus = rx_byte;
										ccr_pkg::IDX_MEM: nxt_mem = rx_byte & ccr_pkg::MEM_WMASK;
										ccr_pkg::IDX_SPR: nxt_spr = rx_byte[1:0];
										ccr_pkg::IDX_REF: nxt_ref = rx_byte[1:0];
										default:          nxt_spr = spr_ff;
									endcase
								end
							end
						end else if (scl_fall && got_ff) begin
							nxt_oe = 1'b1;  nxt_got = 1'b0;  nxt_st = ccr_pkg::ST_ACK;
						end
					end
					ccr_pkg::ST_READ: begin
						if (scl_rise) begin
							nxt_cnt = cnt_ff + 3'h1;
							if (cnt_ff == ccr_pkg::BIT_LAST) nxt_got = 1'b1;
						end else if (scl_fall) begin
							if (got_ff) begin
								nxt_oe = 1'b0;  nxt_got = 1'b0;  nxt_st = ccr_pkg::ST_RACK;
							end else begin
								nxt_shift = {shift_ff[6:0], 1'b0};
								nxt_oe = ~shift_ff[6];
							end
						end
					end
					ccr_pkg::ST_RACK: begin
						if (scl_rise) begin
							if (s2_ff.sda) begin
								nxt_st = ccr_pkg::ST_IDLE;  // Master refused; wait for stop
							end else begin
								nxt_got = 1'b1;
								if (idx_ff != ccr_pkg::IDX_MAX) nxt_idx = idx_ff + 3'h1;
							end
						end else if (scl_fall && got_ff) begin
							nxt_shift = rd_byte(idx_ff, bus_ff, mem_ff, spr_ff, ref_ff, strap_ff);
							nxt_oe = ~nxt_shift[7];  nxt_cnt = 3'h0;  nxt_got = 1'b0;
							nxt_st = ccr_pkg::ST_READ;
						end
					end
					default: nxt_st = ccr_pkg::ST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= ccr_pkg::ST_IDLE;  cnt_ff <= 3'h0;  shift_ff <= 8'h00;  got_ff <= 1'b0;
			rw_ff <= 1'b0;  hdr_ff <= 2'h0;  idx_ff <= ccr_pkg::IDX_FIRST;  oe_ff <= 1'b0;
			bus_ff <= ccr_pkg::BUS_RST;  mem_ff <= ccr_pkg::MEM_RST;
			spr_ff <= ccr_pkg::SPR_RST;  ref_ff <= ccr_pkg::REF_RST;
			sel_ff <= 1'b0;  strap_ff <= 4'h0;  wait_ff <= 2'h0;  sdone_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;  cnt_ff <= nxt_cnt;  shift_ff <= nxt_shift;  got_ff <= nxt_got;
			rw_ff <= nxt_rw;  hdr_ff <= nxt_hdr;  idx_ff <= nxt_idx;  oe_ff <= nxt_oe;
			bus_ff <= nxt_bus;  mem_ff <= nxt_mem;  spr_ff <= nxt_spr;  ref_ff <= nxt_ref;
			sel_ff <= nxt_sel;  strap_ff <= nxt_strap;  wait_ff <= nxt_wait;  sdone_ff <= nxt_sdone;
		end
	end

	assign sda_out           = 1'b0;  // Open drain: only ever pulls low
	assign sda_oe            = oe_ff;
	assign spread_enable     = spr_ff[ccr_pkg::SPR_EN];
	assign spread_depth_half = spr_ff[ccr_pkg::SPR_DEP];

	// ---------------------------------------------------------------
	// Output gates
	// ---------------------------------------------------------------
	logic [ccr_pkg::N_GATES-1:0] g_src;
	logic [ccr_pkg::N_GATES-1:0] g_en;
	logic [ccr_pkg::N_GATES-1:0] g_out;

	// Shared pin follows the selected rate; the gate masks the switch
	assign g_src[ccr_pkg::G_SHR] = sel_ff ? s2_ff.r48_src : s2_ff.r24_src;
	assign g_en[ccr_pkg::G_SHR]  = mem_ff[ccr_pkg::MEM_SHR] & (sel_ff == mem_ff[ccr_pkg::MEM_SEL]);
	assign g_src[ccr_pkg::G_F48] = s2_ff.r48_src;
	assign g_en[ccr_pkg::G_F48]  = mem_ff[ccr_pkg::MEM_F48];

	genvar gi;
	generate
		for (gi = 0; gi < ccr_pkg::N_BUS; gi++) begin : g_bus
			assign g_src[ccr_pkg::G_BUS+gi] = s2_ff.bus_src;
			assign g_en[ccr_pkg::G_BUS+gi]  = bus_ff[ccr_pkg::BUS_MAP[gi]];
		end
		for (gi = 0; gi < ccr_pkg::N_MEM; gi++) begin : g_mem
			assign g_src[ccr_pkg::G_MEM+gi] = s2_ff.mem_src;
			assign g_en[ccr_pkg::G_MEM+gi]  = mem_ff[gi/ccr_pkg::MEM_GRP];
		end
		for (gi = 0; gi < ccr_pkg::N_REF; gi++) begin : g_ref
			assign g_src[ccr_pkg::G_REF+gi] = s2_ff.ref_src[gi];
			assign g_en[ccr_pkg::G_REF+gi]  = ref_ff[gi];
		end
		for (gi = 0; gi < ccr_pkg::N_GATES; gi++) begin : g_gate
			ccr_gate u_gate (
				.mclk    (mclk),
				.arst_n  (arst_n),
				.ce      (ce),
				.src     (g_src[gi]),
				.en      (g_en[gi]),
				.clk_out (g_out[gi])
			);
		end
	endgenerate

	assign bus_clock_out             = g_out[ccr_pkg::G_BUS +: ccr_pkg::N_BUS];
	assign memory_clock_out          = g_out[ccr_pkg::G_MEM +: ccr_pkg::N_MEM];
	assign shared_rate_clock_out     = g_out[ccr_pkg::G_SHR];
	assign fixed_high_rate_clock_out = g_out[ccr_pkg::G_F48];
	assign reference_out             = g_out[ccr_pkg::G_REF +: ccr_pkg::N_REF];

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	property p_ack_addr;
		(ce && st_ff == ccr_pkg::ST_ADDR && scl_fall && got_ff && !bus_start && !bus_stop)
			|=> (sda_oe && st_ff == ccr_pkg::ST_ACK);
	endproperty
	a_ack_addr: assert property (p_ack_addr) else $error("address not acknowledged");

	property p_bad_addr;
		(ce && st_ff == ccr_pkg::ST_ADDR && scl_rise && cnt_ff == ccr_pkg::BIT_LAST
			&& rx_byte[7:1] != ccr_pkg::SLAVE_ADDR) |=> (st_ff == ccr_pkg::ST_IDLE && !sda_oe);
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("foreign address answered");

	property p_hdr_first;
		$changed(bus_ff) || $changed(mem_ff) || $changed(spr_ff) || $changed(ref_ff)
			|-> $past(hdr_ff) == ccr_pkg::HDR_BYTES;
	endproperty
	a_hdr_first: assert property (p_hdr_first) else $error("register written before header");

	property p_bus_write;
		$changed(bus_ff) |-> $past(wr_en) && $past(idx_ff) == ccr_pkg::IDX_BUS;
	endproperty
	a_bus_write: assert property (p_bus_write) else $error("bus gate byte changed without write");

	property p_id_load;
		(ce && st_ff == ccr_pkg::ST_ACK && scl_fall && rw_ff && idx_ff == ccr_pkg::IDX_ID
			&& !bus_start && !bus_stop) |=> shift_ff == ccr_pkg::CHIP_ID;
	endproperty
	a_id_load: assert property (p_id_load) else $error("identification byte wrong");

	property p_sel_quiet;
		$changed(sel_ff) |-> $past(!s2_ff.r24_src && !s2_ff.r48_src);
	endproperty
	a_sel_quiet: assert property (p_sel_quiet) else $error("rate select moved with a source high");

	property p_strap_hold;
		(sdone_ff && $past(sdone_ff)) |-> $stable(strap_ff);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("latched straps changed");

	property p_mem_rsv;
		(mem_ff & ~ccr_pkg::MEM_WMASK) == 8'h00;
	endproperty
	a_mem_rsv: assert property (p_mem_rsv) else $error("reserved memory byte bit set");

	c_write_bus: cover property (wr_en && idx_ff == ccr_pkg::IDX_BUS);
	c_read_id: cover property (st_ff == ccr_pkg::ST_READ && idx_ff == ccr_pkg::IDX_ID);
	c_read_nack: cover property (st_ff == ccr_pkg::ST_RACK ##1 st_ff == ccr_pkg::ST_IDLE);

endmodule : ccr_clk_ctrl

// file: rtl/ccr_pkg.sv
// Shared constants, types and state codes of the clock output control registers
package ccr_pkg;

	// ---------------------------------------------------------------
	// Serial slave port
	// ---------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR = 7'h69;  // 1101001
	localparam logic [1:0] HDR_BYTES  = 2'h2;   // Command code and byte count, both ignored
	localparam logic [2:0] BIT_LAST   = 3'h7;

	// ---------------------------------------------------------------
	// Byte indices in the sequence
	// ---------------------------------------------------------------
	localparam logic [2:0] IDX_FIRST = 3'h0;
	localparam logic [2:0] IDX_BUS   = 3'h2;
	localparam logic [2:0] IDX_MEM   = 3'h3;
	localparam logic [2:0] IDX_SPR   = 3'h4;
	localparam logic [2:0] IDX_REF   = 3'h5;
	localparam logic [2:0] IDX_ID    = 3'h6;
	localparam logic [2:0] IDX_MAX   = 3'h7;  // Saturates; bytes past the map are ignored

	// ---------------------------------------------------------------
	// Reset values and field layout
	// ---------------------------------------------------------------
	localparam logic [7:0] BUS_RST   = 8'hff;  // Reserved bits power up as one as well
	localparam logic [7:0] MEM_RST   = 8'h37;
	localparam logic [7:0] MEM_WMASK = 8'h77;  // Bits 7 and 3 reserved
	localparam logic [1:0] SPR_RST   = 2'h0;
	localparam logic [1:0] REF_RST   = 2'h3;
	localparam logic [7:0] CHIP_ID   = 8'h3c;  // Arbitrary value, fixed in the device
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [1:0] RSV_ZERO2 = 2'h0;
	localparam logic [5:0] RSV_ZERO6 = 6'h00;

	localparam int BUS_MAP [6] = '{6, 0, 1, 2, 3, 4};  // Gate bit of bus clock 0..5
	localparam int MEM_SEL  = 6;
	localparam int MEM_F48  = 5;
	localparam int MEM_SHR  = 4;
	localparam int MEM_GRP  = 4;  // Memory outputs per group bit
	localparam int SPR_DEP  = 1;
	localparam int SPR_EN   = 0;

	// ---------------------------------------------------------------
	// Gated output vector layout
	// ---------------------------------------------------------------
	localparam int N_BUS   = 6;
	localparam int N_MEM   = 12;
	localparam int N_REF   = 2;
	localparam int G_BUS   = 0;
	localparam int G_MEM   = 6;
	localparam int G_SHR   = 18;
	localparam int G_F48   = 19;
	localparam int G_REF   = 20;
	localparam int N_GATES = 22;

	localparam logic [1:0] STRAP_WAIT = 2'h3;  // Lets the strap pins clear the synchroniser

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_ACK   = 3'b010,
		ST_WRITE = 3'b011,
		ST_READ  = 3'b100,
		ST_RACK  = 3'b101
	} ccr_state_t;

	typedef struct packed {
		logic       scl;
		logic       sda;
		logic [3:0] strap_n;
		logic       bus_src;
		logic       mem_src;
		logic       r24_src;
		logic       r48_src;
		logic [1:0] ref_src;
	} ccr_pins_t;

endpackage : ccr_pkg

// file: rtl/ccr_gate.sv
// Glitch-free gate for one clock output
`timescale 1ns/1ps
module ccr_gate (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic ce,
	// Source clock level and enable
	input  wire logic src,
	input  wire logic en,
	// Gated output
	output logic      clk_out
);

	logic act_ff;
	logic nxt_act;
	logic out_ff;
	logic nxt_out;

	// Enable is taken only while the source is low, so no pulse is cut short
	always_comb begin
		nxt_act = act_ff;
		nxt_out = out_ff;
		if (ce) begin
			if (!src) begin
				nxt_act = en;
			end
			nxt_out = src & act_ff;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			act_ff <= 1'b1;
			out_ff <= 1'b0;
		end else begin
			act_ff <= nxt_act;
			out_ff <= nxt_out;
		end
	end

	assign clk_out = out_ff;

	property p_act_low;
		@(posedge mclk) disable iff (!arst_n)
		$changed(act_ff) |-> $past(!src);
	endproperty
	a_act_low: assert property (p_act_low) else $error("gate enable changed while source high");

	property p_full_high;
		@(posedge mclk) disable iff (!arst_n)
		(ce && out_ff && src) |=> out_ff;
	endproperty
	a_full_high: assert property (p_full_high) else $error("gated high pulse cut short");

endmodule : ccr_gate

// file: test/ccr_i2c_master.sv
// Serial bus master model that programs and reads back the control bytes
`timescale 1ns/1ps
module ccr_i2c_master (
	// Clock
	input  wire logic mclk,
	// Bus lines (data is open drain with a pull-up)
	input  wire logic sda_in,
	output logic      scl,
	output logic      sda_pull
);
	// ---------------------------------------------------------------
	// Bit timing
	// ---------------------------------------------------------------
	localparam int HALF = 5;  // Above the four-cycle minimum half period

	// Clock driven high and data released at power-up, so the pull-up holds data high
	initial begin
		scl      = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic hold();
		repeat (HALF) @(negedge mclk);
	endtask : hold

	// Start or repeated start: data falls while the clock is high
	task automatic start();
		sda_pull = 1'b0;
		hold();
		scl = 1'b1;
		hold();
		sda_pull = 1'b1;
		hold();
		scl = 1'b0;
		hold();
	endtask : start

	// Stop: data rises while the clock is high
	task automatic stop();
		sda_pull = 1'b1;
		hold();
		scl = 1'b1;
		hold();
		sda_pull = 1'b0;
		hold();
	endtask : stop

	// Data moves only in the low phase so no false start or stop is seen
	task automatic bit_io(input logic b, output logic s);
		sda_pull = ~b;
		hold();
		scl = 1'b1;
		hold();
		s   = sda_in;
		scl = 1'b0;
		hold();
	endtask : bit_io

	// Byte out MSB first, then the device's acknowledge
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask : wr_byte

	// Byte in MSB first; a not-acknowledge on the last byte ends the read
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, s);
	endtask : rd_byte
endmodule : ccr_i2c_master

// file: test/ccr_clk_ctrl_bench.sv
// Self-checking testbench of the clock output control registers
`timescale 1ns/1ps
module ccr_clk_ctrl_bench;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	localparam logic [3:0] STRAP = 4'ha;
	logic        mclk, arst_n, scl, sda_pull, sda_wire, sda_out, sda_oe;
	logic        shr_out, f48_out, spr_en, spr_dep;
	logic [3:0]  strap_n;
	logic [7:0]  ph;
	logic [5:0]  bus_out;
	logic [11:0] mem_out;
	logic [1:0]  ref_out;
	logic [21:0] gv;
	int          num_errors;
	int          n_checks;

	// Wired-AND data line with pull-up
	assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));
	assign gv       = {ref_out, f48_out, shr_out, mem_out, bus_out};

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Slow source clocks from one counter, so every period divides 64
	always @(negedge mclk) begin
		ph <= ph + 8'h01;
	end

	ccr_clk_ctrl u_dut (
		.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe(sda_oe), .freq_strap_n(strap_n),
		.bus_clock_src(ph[3]), .mem_clock_src(ph[2]), .low_rate_src(ph[4]), .high_rate_src(ph[2]),
		.reference_src({ph[4], ph[3]}), .bus_clock_out(bus_out), .memory_clock_out(mem_out),
		.shared_rate_clock_out(shr_out), .fixed_high_rate_clock_out(f48_out), .reference_out(ref_out),
		.spread_enable(spr_en), .spread_depth_half(spr_dep)
	);

	ccr_i2c_master u_mst (.mclk(mclk), .sda_in(sda_wire), .scl(scl), .sda_pull(sda_pull));

	// ---------------------------------------------------------------
	// Compare, bus and output tasks
	// ---------------------------------------------------------------
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask : chk8

	task automatic chkn(input string nm, input int e, input int g);
		n_checks++;
		if (g != e) begin
			$display("FAIL %s expected %0d seen %0d", nm, e, g);
			num_errors++;
		end
	endtask : chkn

	// Address, two ignored header bytes, then bytes 0..6 in order
	task automatic wr_seq(input logic [55:0] v);
		logic ack;
		u_mst.start();
		u_mst.wr_byte(8'hd2, ack);
		chk8("address ack", 8'h01, {7'h00, ack});
		repeat (2) begin
			u_mst.wr_byte(8'ha5, ack);
			chk8("header ack", 8'h01, {7'h00, ack});
		end
		for (int i = 0; i < 7; i++) begin
			u_mst.wr_byte(v[8*i +: 8], ack);
			chk8("data ack", 8'h01, {7'h00, ack});
		end
		u_mst.stop();
	endtask : wr_seq

	task automatic rd_seq(input logic [55:0] e);
		logic       ack;
		logic [7:0] d;
		u_mst.start();
		u_mst.wr_byte(8'hd3, ack);
		chk8("read address ack", 8'h01, {7'h00, ack});
		for (int i = 0; i < 7; i++) begin
			u_mst.rd_byte(i == 6, d);
			chk8("read byte", e[8*i +: 8], d);
		end
		u_mst.stop();
	endtask : rd_seq

	// Counting rises over whole source periods is immune to the gate latency
	task automatic check_out(input logic [7:0] bus, input logic [7:0] mem, input logic [1:0] rf,
				input logic [1:0] spr);
		int          cnt [22];
		int          e;
		logic [21:0] prev;
		repeat (40) @(posedge mclk);
		#1;
		prev = gv;
		foreach (cnt[i]) cnt[i] = 0;
		repeat (64) begin
			@(posedge mclk);
			#1;
			for (int i = 0; i < 22; i++) cnt[i] += int'(gv[i] & ~prev[i]);
			prev = gv;
		end
		for (int i = 0; i < 22; i++) begin
			if (i < 6) e = bus[(i == 0) ? 6 : i - 1] ? 4 : 0;
			else if (i < 18) e = mem[(i - 6) / 4] ? 8 : 0;
			else if (i == 18) e = mem[4] ? (mem[6] ? 8 : 2) : 0;
			else if (i == 19) e = mem[5] ? 8 : 0;
			else e = rf[i - 20] ? ((i == 20) ? 4 : 2) : 0;
			chkn("gated rises", e, cnt[i]);
		end
		chk8("spread outputs", {6'h00, spr}, {6'h00, spr_dep, spr_en});
	endtask : check_out

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic sc_reset();
		rd_seq({8'h3c, 8'h03, STRAP, 4'h0, 8'h37, 8'hff, 8'h00, 8'h00});
		check_out(8'hff, 8'h37, 2'h3, 2'h0);
	endtask : sc_reset

	// Reserved bits set, rate select flipped, chip code written
	task automatic sc_write_a();
		wr_seq({8'h00, 8'hfe, 8'hff, 8'hd9, 8'h5a, 8'h77, 8'h55});
		rd_seq({8'h3c, 8'h02, STRAP, 4'h3, 8'h51, 8'h5a, 8'h00, 8'h00});
		check_out(8'h5a, 8'h51, 2'h2, 2'h3);
	endtask : sc_write_a

	// A foreign address is refused; the next full write still lands
	task automatic sc_bad_addr();
		logic ack;
		u_mst.start();
		u_mst.wr_byte(8'hd4, ack);
		chk8("foreign address ack", 8'h00, {7'h00, ack});
		u_mst.stop();
		wr_seq({8'hff, 8'h01, 8'h02, 8'h26, 8'ha5, 8'h00, 8'h00});
		rd_seq({8'h3c, 8'h01, STRAP, 4'h2, 8'h26, 8'ha5, 8'h00, 8'h00});
		check_out(8'ha5, 8'h26, 2'h1, 2'h2);
	endtask : sc_bad_addr

	task automatic tally_and_finish();
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish

	// Main sequence; every wait is a fixed count, so nothing can hang
	initial begin
		num_errors = 0;
		n_checks   = 0;
		arst_n     = 1'b0;
		strap_n    = STRAP;
		ph         = 8'h00;
		repeat (12) @(negedge mclk);
		arst_n = 1'b1;
		repeat (8) @(negedge mclk);
		sc_reset();
		sc_write_a();
		sc_bad_addr();
		tally_and_finish();
	end
endmodule : ccr_clk_ctrl_bench
